// ===== opaddr_monitor.sv
`timescale 1ns/1ps
module opaddr_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire opaddr_pkg::req_t req,
    input wire logic bank_select_low_flag,
    input wire logic bank_select_high_flag,
    input wire logic [opaddr_pkg::REG_COUNT-1:0][7:0] regs,
    input wire logic [15:0] stack_pointer,
    input wire opaddr_pkg::result_t result
);
    logic [4:0] base_i;
    logic [15:0] hl;
    logic [15:0] de;
    logic [7:0] b_reg;
    logic plain;
    always_comb begin
        base_i = {bank_select_high_flag, bank_select_low_flag, 3'h0};
        hl = {regs[base_i + 5'h7], regs[base_i + 5'h6]};
        de = {regs[base_i + 5'h5], regs[base_i + 5'h4]};
        b_reg = regs[base_i + 5'h3];
        plain = req.valid && !(req.opcode inside {8'h85, 8'hae, 8'hab, 8'h8e});
    end
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_short_window: assert property (plain && req.mode == opaddr_pkg::mode_short |=>
        result.valid && result.addr == {7'h7f, $past(req.imm_lo) < 8'h20, $past(req.imm_lo)})
        else $error("short direct address wrong");
    a_sfr_gap_flag: assert property (plain && req.mode == opaddr_pkg::mode_sfr |=>
        result.addr[15:8] == 8'hff && result.fault.sfr_gap == ($past(req.imm_lo) inside {[8'hd0:8'hdf]}))
        else $error("sfr address or gap flag wrong");
    a_direct_pair: assert property (req.valid && req.opcode == 8'h8e |=>
        result.addr == {$past(req.imm_hi), $past(req.imm_lo)})
        else $error("direct address byte order wrong");
    a_ind_pointer: assert property (req.valid && req.opcode == 8'h85 |=>
        result.addr == $past(de) && result.load_acc)
        else $error("pointer indirect address wrong");
    a_based_carry: assert property (req.valid && req.opcode == 8'hae |=>
        result.addr == 16'($past(hl) + $past(req.imm_lo)))
        else $error("based address wrong");
    a_based_index: assert property (req.valid && req.opcode == 8'hab |=>
        result.addr == 16'($past(hl) + $past(b_reg)))
        else $error("based indexed address wrong");
    a_stack_bound: assert property (plain && req.mode == opaddr_pkg::mode_stack |=>
        result.fault.stack_range == (result.addr < 16'hfb00 || result.addr > 16'hfeff))
        else $error("stack range flag wrong");
    a_stack_push: assert property (plain && req.mode == opaddr_pkg::mode_stack &&
        req.stk_op == opaddr_pkg::stk_push_byte |=> result.addr == 16'($past(stack_pointer) - 16'h1))
        else $error("byte push address wrong");
    a_mult_implied: assert property (plain && req.mode == opaddr_pkg::mode_implied &&
        req.imp_op == opaddr_pkg::unsigned_byte_multiply |=>
        result.is_reg && result.dst_pair && !result.src_pair && result.is_word)
        else $error("multiply operands wrong");
    a_idle_quiet: assert property (!req.valid |=> !result.valid)
        else $error("result without request");
endmodule : opaddr_monitor

// ===== opaddr_pkg.sv
// Operation
// - multiply reads accumulator byte, writes the 16-bit product to the accumulator pair
// - word divide takes dividend from accumulator pair, returns quotient there
// - decimal adjust and nibble rotate implicitly use the accumulator byte
// - byte register picked by 3-bit code inside bank chosen by both bank flags
// - byte codes 0-7 and pair codes 0-3 map in fixed order within bank
// - direct address is low immediate byte then high immediate byte
// - short direct 8-bit immediate reaches only the 256-byte window fe20-ff1f
// - short window: fast RAM fe20-feff, special registers ff00-ff1f
// - short direct address bit 8 clear for 20-ff, set for 00-1f
// - word short direct operands must sit at even addresses
// - special register addressing reaches ff00-ffcf and ffe0-ffff, not the gap
// - lowest 32 special registers also reachable through short direct addressing
// - word special register operands only for word-capable registers at even addresses
// - register indirect uses pointer pair or base pair of the selected bank
// - based adds zero-extended 8-bit immediate to base pair, carry dropped
// - based indexed adds zero-extended byte index to base pair, carry dropped
// - stack address comes from stack pointer for push, pop, call, return, interrupt
// - stack accesses confined to internal fast RAM area
// - opcode 85 loads accumulator through pointer pair indirectly
// - opcode ae loads accumulator based, followed by one offset byte
package opaddr_pkg;

    localparam int unsigned NUM_BANKS = 4;
    localparam int unsigned REGS_PER_BANK = 8;
    localparam int unsigned REG_COUNT = NUM_BANKS * REGS_PER_BANK;

    // byte register codes, fixed order within a bank
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;

    // pair codes; pair n joins byte codes 2n (low) and 2n+1 (high)
    localparam logic [1:0] PAIR_AX = 2'h0;
    localparam logic [1:0] PAIR_BC = 2'h1;
    localparam logic [1:0] PAIR_DE = 2'h2;
    localparam logic [1:0] PAIR_HL = 2'h3;

    localparam logic [6:0] SHORT_PAGE_TOP = 7'h7f;
    localparam logic [7:0] SHORT_SPLIT = 8'h20;
    localparam logic [15:0] SHORT_LO = 16'hfe20;
    localparam logic [15:0] SHORT_HI = 16'hff1f;
    localparam logic [15:0] SHORT_RAM_HI = 16'hfeff;
    localparam logic [15:0] SHORT_SFR_LO = 16'hff00;

    localparam logic [7:0] SFR_PAGE = 8'hff;
    localparam logic [7:0] SFR_GAP_LO = 8'hd0;
    localparam logic [7:0] SFR_GAP_HI = 8'hdf;
    localparam int unsigned SFR_WORD_COUNT = 10;
    localparam logic [SFR_WORD_COUNT-1:0][7:0] SFR_WORD_OFFS = {
        8'h68, 8'h6a, 8'h6c, 8'h6e, 8'he0, 8'he2, 8'he4, 8'he6, 8'he8, 8'hea
    };

    localparam logic [15:0] FAST_RAM_LO = 16'hfb00;
    localparam logic [15:0] FAST_RAM_HI = 16'hfeff;

    localparam logic [7:0] OPC_LOAD_A_IND_PTR = 8'h85;
    localparam logic [7:0] OPC_LOAD_A_BASED = 8'hae;
    localparam logic [7:0] OPC_LOAD_A_BASED_B = 8'hab;
    localparam logic [7:0] OPC_LOAD_A_DIRECT = 8'h8e;

    localparam logic [1:0] STK_DEC_BYTE = 2'h1;
    localparam logic [1:0] STK_DEC_WORD = 2'h2;
    localparam logic [1:0] STK_DEC_INT = 2'h3;

    typedef enum logic [3:0] {
        mode_none,
        mode_implied,
        mode_reg_byte,
        mode_reg_pair,
        mode_direct,
        mode_short,
        mode_sfr,
        mode_ind_pointer,
        mode_ind_base,
        mode_based,
        mode_based_b,
        mode_based_c,
        mode_stack
    } addr_mode_t;

    typedef enum logic [2:0] {
        unsigned_byte_multiply,
        unsigned_word_divide,
        decimal_adjust_after_add,
        decimal_adjust_after_subtract,
        nibble_rotate_right,
        nibble_rotate_left
    } implied_op_t;

    typedef enum logic [2:0] {
        stk_push_byte,
        stk_push_word,
        stk_pop_byte,
        stk_pop_word,
        stk_call,
        stk_return,
        stk_int_save
    } stack_op_t;

    typedef struct packed {
        logic valid;
        addr_mode_t mode;
        implied_op_t imp_op;
        stack_op_t stk_op;
        logic [7:0] opcode;
        logic [7:0] imm_lo;
        logic [7:0] imm_hi;
        logic [2:0] byte_register_code;
        logic [1:0] pair_register_code;
        logic word;
    } req_t;

    typedef struct packed {
        logic misaligned;
        logic no_word_access;
        logic sfr_gap;
        logic stack_range;
    } fault_t;

    typedef struct packed {
        logic valid;
        logic is_reg;
        logic src_pair;
        logic [4:0] src_index;
        logic has_dst;
        logic dst_pair;
        logic [4:0] dst_index;
        logic [15:0] addr;
        logic is_word;
        logic load_acc;
        fault_t fault;
    } result_t;

endpackage : opaddr_pkg

// ===== operand_address_generator.sv
`timescale 1ns/1ps
module operand_address_generator (
    input wire logic clk,
    input wire logic rst_n,
    input wire opaddr_pkg::req_t req,
    input wire logic bank_select_low_flag,
    input wire logic bank_select_high_flag,
    input wire logic [opaddr_pkg::REG_COUNT-1:0][7:0] regs,
    input wire logic [15:0] stack_pointer,
    output opaddr_pkg::result_t result
);

    typedef struct packed {
        opaddr_pkg::result_t res;
    } state_t;

    state_t st_q;
    state_t st_d;

    logic [1:0] bank;
    logic [15:0] base_pair;
    logic [15:0] pointer_pair;
    logic [7:0] based_offset;
    logic [15:0] based_sum;
    opaddr_pkg::addr_mode_t eff_mode;

    // flat register index: bank in the upper bits, byte code below
    function automatic logic [4:0] byte_index(input logic [1:0] b, input logic [2:0] code);
        byte_index = {b, code};
    endfunction : byte_index

    function automatic logic [4:0] pair_index(input logic [1:0] b, input logic [1:0] code);
        pair_index = {b, code, 1'b0};
    endfunction : pair_index

    function automatic logic [15:0] pair_value(
        input logic [opaddr_pkg::REG_COUNT-1:0][7:0] rf,
        input logic [1:0] b,
        input logic [1:0] code
    );
        logic [4:0] lo;
        lo = pair_index(b, code);
        pair_value = {rf[lo | 5'h01], rf[lo]};
    endfunction : pair_value

    // opcodes whose addressing is fixed override the decoder's mode field
    function automatic opaddr_pkg::addr_mode_t opcode_mode(
        input logic [7:0] opc,
        input opaddr_pkg::addr_mode_t fallback
    );
        case (opc)
            opaddr_pkg::OPC_LOAD_A_IND_PTR: opcode_mode = opaddr_pkg::mode_ind_pointer;
            opaddr_pkg::OPC_LOAD_A_BASED: opcode_mode = opaddr_pkg::mode_based;
            opaddr_pkg::OPC_LOAD_A_BASED_B: opcode_mode = opaddr_pkg::mode_based_b;
            opaddr_pkg::OPC_LOAD_A_DIRECT: opcode_mode = opaddr_pkg::mode_direct;
            default: opcode_mode = fallback;
        endcase
    endfunction : opcode_mode

    function automatic logic opcode_loads_acc(input logic [7:0] opc);
        opcode_loads_acc = (opc == opaddr_pkg::OPC_LOAD_A_IND_PTR)
            || (opc == opaddr_pkg::OPC_LOAD_A_BASED)
            || (opc == opaddr_pkg::OPC_LOAD_A_BASED_B)
            || (opc == opaddr_pkg::OPC_LOAD_A_DIRECT);
    endfunction : opcode_loads_acc

    function automatic logic sfr_word_capable(input logic [7:0] offs);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < opaddr_pkg::SFR_WORD_COUNT; i++) begin
            if (opaddr_pkg::SFR_WORD_OFFS[i] == offs) begin
                hit = 1'b1;
            end
        end
        sfr_word_capable = hit;
    endfunction : sfr_word_capable

    function automatic logic in_fast_ram(input logic [15:0] a);
        in_fast_ram = (a >= opaddr_pkg::FAST_RAM_LO) && (a <= opaddr_pkg::FAST_RAM_HI);
    endfunction : in_fast_ram

    assign bank = {bank_select_high_flag, bank_select_low_flag};
    assign base_pair = pair_value(regs, bank, opaddr_pkg::PAIR_HL);
    assign pointer_pair = pair_value(regs, bank, opaddr_pkg::PAIR_DE);
    assign eff_mode = opcode_mode(req.opcode, req.mode);

    // one adder serves immediate offset and both index registers
    always_comb begin
        case (eff_mode)
            opaddr_pkg::mode_based_b: based_offset = regs[byte_index(bank, opaddr_pkg::REG_B)];
            opaddr_pkg::mode_based_c: based_offset = regs[byte_index(bank, opaddr_pkg::REG_C)];
            default: based_offset = req.imm_lo;
        endcase
    end

    zero_ext_adder #(
        .BASE_W(16),
        .OFFS_W(8)
    ) u_based_adder (
        .base(base_pair),
        .offset(based_offset),
        .sum(based_sum)
    );

    always_comb begin
        logic [15:0] stk_addr;
        logic [1:0] stk_dec;
        logic [15:0] short_addr;
        st_d = st_q;
        stk_addr = stack_pointer;
        stk_dec = 2'h0;
        short_addr = 16'h0000;
        st_d.res = '0;
        st_d.res.valid = req.valid;
        st_d.res.is_word = req.word;
        st_d.res.load_acc = opcode_loads_acc(req.opcode);
        if (req.valid) begin
            case (eff_mode)
                opaddr_pkg::mode_implied: begin
                    st_d.res.is_reg = 1'b1;
                    case (req.imp_op)
                        opaddr_pkg::unsigned_byte_multiply: begin
                            st_d.res.src_index = byte_index(bank, opaddr_pkg::REG_A);
                            st_d.res.has_dst = 1'b1;
                            st_d.res.dst_pair = 1'b1;
                            st_d.res.dst_index = pair_index(bank, opaddr_pkg::PAIR_AX);
                            st_d.res.is_word = 1'b1;
                        end
                        opaddr_pkg::unsigned_word_divide: begin
                            st_d.res.src_pair = 1'b1;
                            st_d.res.src_index = pair_index(bank, opaddr_pkg::PAIR_AX);
                            st_d.res.has_dst = 1'b1;
                            st_d.res.dst_pair = 1'b1;
                            st_d.res.dst_index = pair_index(bank, opaddr_pkg::PAIR_AX);
                            st_d.res.is_word = 1'b1;
                        end
                        default: begin
                            // adjust and nibble rotate correct the accumulator in place
                            st_d.res.src_index = byte_index(bank, opaddr_pkg::REG_A);
                            st_d.res.has_dst = 1'b1;
                            st_d.res.dst_index = byte_index(bank, opaddr_pkg::REG_A);
                            st_d.res.is_word = 1'b0;
                        end
                    endcase
                end
                opaddr_pkg::mode_reg_byte: begin
                    st_d.res.is_reg = 1'b1;
                    st_d.res.src_index = byte_index(bank, req.byte_register_code);
                    st_d.res.is_word = 1'b0;
                end
                opaddr_pkg::mode_reg_pair: begin
                    st_d.res.is_reg = 1'b1;
                    st_d.res.src_pair = 1'b1;
                    st_d.res.src_index = pair_index(bank, req.pair_register_code);
                    st_d.res.is_word = 1'b1;
                end
                opaddr_pkg::mode_direct: begin
                    st_d.res.addr = {req.imm_hi, req.imm_lo};
                end
                opaddr_pkg::mode_short: begin
                    // low immediates wrap to the special register part above the RAM
                    short_addr = {opaddr_pkg::SHORT_PAGE_TOP,
                                  (req.imm_lo < opaddr_pkg::SHORT_SPLIT),
                                  req.imm_lo};
                    st_d.res.addr = short_addr;
                    st_d.res.fault.misaligned = req.word && short_addr[0];
                end
                opaddr_pkg::mode_sfr: begin
                    st_d.res.addr = {opaddr_pkg::SFR_PAGE, req.imm_lo};
                    st_d.res.fault.sfr_gap = (req.imm_lo >= opaddr_pkg::SFR_GAP_LO)
                        && (req.imm_lo <= opaddr_pkg::SFR_GAP_HI);
                    st_d.res.fault.misaligned = req.word && req.imm_lo[0];
                    st_d.res.fault.no_word_access = req.word
                        && !sfr_word_capable(req.imm_lo);
                end
                opaddr_pkg::mode_ind_pointer: begin
                    st_d.res.addr = pointer_pair;
                end
                opaddr_pkg::mode_ind_base: begin
                    st_d.res.addr = base_pair;
                end
                opaddr_pkg::mode_based,
                opaddr_pkg::mode_based_b,
                opaddr_pkg::mode_based_c: begin
                    st_d.res.addr = based_sum;
                end
                opaddr_pkg::mode_stack: begin
                    // pushes point at the lowest byte written after the pre-decrement
                    case (req.stk_op)
                        opaddr_pkg::stk_push_byte: stk_dec = opaddr_pkg::STK_DEC_BYTE;
                        opaddr_pkg::stk_push_word: stk_dec = opaddr_pkg::STK_DEC_WORD;
                        opaddr_pkg::stk_call: stk_dec = opaddr_pkg::STK_DEC_WORD;
                        opaddr_pkg::stk_int_save: stk_dec = opaddr_pkg::STK_DEC_INT;
                        default: stk_dec = 2'h0;
                    endcase
                    stk_addr = stack_pointer - {14'h0000, stk_dec};
                    st_d.res.addr = stk_addr;
                    st_d.res.is_word = (req.stk_op != opaddr_pkg::stk_push_byte)
                        && (req.stk_op != opaddr_pkg::stk_pop_byte);
                    // a stack outside fast RAM is flagged, not redirected
                    st_d.res.fault.stack_range = !in_fast_ram(stk_addr);
                end
                default: begin
                    st_d.res.valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign result = st_q.res;

endmodule : operand_address_generator

// ===== reg_file_model.sv
`timescale 1ns/1ps
module reg_file_model (
    input wire logic clk,
    input wire logic shuffle,
    output logic [opaddr_pkg::REG_COUNT-1:0][7:0] regs,
    output logic [15:0] stack_pointer,
    output logic bank_select_low_flag,
    output logic bank_select_high_flag
);
    initial begin
        regs = '0;
        stack_pointer = 16'hfe00;
        bank_select_low_flag = 1'b0;
        bank_select_high_flag = 1'b0;
    end
    // contents only move on command, so an operand stays put across its request
    always @(posedge clk) begin
        if (shuffle) begin
            for (int i = 0; i < opaddr_pkg::REG_COUNT; i++) begin
                regs[i] <= 8'($urandom);
            end
            // straddles both fast ram bounds to exercise the range flag
            stack_pointer <= 16'(16'hfaf0 + $urandom_range(0, 16'h420));
            bank_select_low_flag <= 1'($urandom);
            bank_select_high_flag <= 1'($urandom);
        end
    end
endmodule : reg_file_model

// ===== test_operand_address_generator.sv
`timescale 1ns/1ps
module test_operand_address_generator;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic shuffle = 1'b0;
    opaddr_pkg::req_t req = '0;
    logic bsl;
    logic bsh;
    logic [opaddr_pkg::REG_COUNT-1:0][7:0] regs;
    logic [15:0] sp;
    opaddr_pkg::result_t result;
    int n_errors = 0;
    int n_compared = 0;
    initial forever #10 clk = ~clk;
    reg_file_model partner (.clk(clk), .shuffle(shuffle), .regs(regs), .stack_pointer(sp),
        .bank_select_low_flag(bsl), .bank_select_high_flag(bsh));
    operand_address_generator uut (.clk(clk), .rst_n(rst_n), .req(req),
        .bank_select_low_flag(bsl), .bank_select_high_flag(bsh), .regs(regs),
        .stack_pointer(sp), .result(result));
    task automatic check(input logic [15:0] got, input int expv, input string what);
        n_compared++;
        if (got !== 16'(expv)) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, 16'(expv));
        end
    endtask : check
    function automatic int pv(input int b, input int n);
        return regs[b*8+2*n+1] * 256 + regs[b*8+2*n];
    endfunction : pv
    task automatic send(input opaddr_pkg::req_t r);
        int b;
        int k;
        int e;
        int off;
        @(posedge clk);
        req <= r;
        @(posedge clk);
        #1;
        b = {bsh, bsl};
        k = r.imm_lo;
        check(result.valid, r.valid && (r.mode != opaddr_pkg::mode_none || r.opcode != 8'h00), "valid");
        if (!r.valid) return;
        check(result.load_acc, r.opcode != 8'h00, "load_acc");
        if (r.opcode == 8'h85) check(result.addr, pv(b, 2), "ind");
        else if (r.opcode == 8'hae) check(result.addr, (pv(b, 3) + k) % 65536, "based");
        else if (r.opcode == 8'hab) check(result.addr, (pv(b, 3) + regs[b*8+3]) % 65536, "idx");
        else if (r.opcode == 8'h8e) check(result.addr, r.imm_hi * 256 + k, "direct");
        else case (r.mode)
            opaddr_pkg::mode_short: begin
                check(result.addr, (k < 32) ? 16'hff00 + k : 16'hfe00 + k, "short");
                check(result.fault.misaligned, r.word & k[0], "s_align");
            end
            opaddr_pkg::mode_sfr: begin
                check(result.addr, 16'hff00 + k, "sfr");
                check(result.fault.sfr_gap, k >= 8'hd0 && k <= 8'hdf, "gap");
                check(result.fault.misaligned, r.word & k[0], "f_align");
                check(result.fault.no_word_access, r.word && !(k inside {8'h68, 8'h6a, 8'h6c,
                    8'h6e, 8'he0, 8'he2, 8'he4, 8'he6, 8'he8, 8'hea}), "word");
            end
            opaddr_pkg::mode_stack: begin
                off = (r.stk_op == opaddr_pkg::stk_push_byte) ? 1 :
                    (r.stk_op inside {opaddr_pkg::stk_push_word, opaddr_pkg::stk_call}) ? 2 :
                    (r.stk_op == opaddr_pkg::stk_int_save) ? 3 : 0;
                e = (sp + 65536 - off) % 65536;
                check(result.addr, e, "stack");
                check(result.fault.stack_range, e < 16'hfb00 || e > 16'hfeff, "range");
                check(result.is_word, !(r.stk_op inside {opaddr_pkg::stk_push_byte,
                    opaddr_pkg::stk_pop_byte}), "s_word");
            end
            opaddr_pkg::mode_implied: begin
                e = (r.imp_op == opaddr_pkg::unsigned_byte_multiply) ? 5'b10111 :
                    (r.imp_op == opaddr_pkg::unsigned_word_divide) ? 5'b11111 : 5'b10100;
                check({result.is_reg, result.src_pair, result.has_dst, result.dst_pair,
                    result.is_word}, e, "implied");
                off = (r.imp_op == opaddr_pkg::unsigned_word_divide) ? 0 : 1;
                check(result.src_index, b*8 + off, "acc");
                off = (r.imp_op inside {opaddr_pkg::unsigned_byte_multiply,
                    opaddr_pkg::unsigned_word_divide}) ? 0 : 1;
                check(result.dst_index, b*8 + off, "acc_dst");
            end
            opaddr_pkg::mode_reg_byte: check(result.src_index, b*8+r.byte_register_code, "reg");
            opaddr_pkg::mode_reg_pair: check({result.src_pair, result.src_index},
                32 + b*8 + 2*r.pair_register_code, "pair");
            opaddr_pkg::mode_ind_base: check(result.addr, pv(b, 3), "ind_base");
            opaddr_pkg::mode_based_c: check(result.addr, (pv(b, 3) + regs[b*8+2]) % 65536, "idx_c");
            opaddr_pkg::mode_direct: check(result.addr, r.imm_hi * 256 + k, "direct_m");
            default: ;
        endcase
    endtask : send
    task automatic stop_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    initial begin
        opaddr_pkg::req_t r;
        int sel;
        void'($urandom(32'hdc8d));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            // mid-run reset; req is dropped too so no checker attempt straddles the release
            if (i == 200) begin
                @(posedge clk);
                rst_n <= 1'b0;
                req <= '0;
                repeat (2) @(posedge clk);
                #1;
                n_compared++;
                if (result !== '0) begin
                    n_errors++;
                    $display("MISMATCH t=%0t result not cleared by reset", $time);
                end
                @(posedge clk);
                rst_n <= 1'b1;
            end
            if (i % 8 == 0) begin
                @(posedge clk);
                shuffle <= 1'b1;
                @(posedge clk);
                shuffle <= 1'b0;
            end
            r = '0;
            r.valid = (i % 37 != 5);
            r.imm_lo = (i < 12) ? 8'(64'h1f20cfd0df00ffe0 >> (8 * (i % 8))) : 8'($urandom);
            r.imm_hi = 8'($urandom);
            r.word = 1'($urandom);
            r.byte_register_code = 3'($urandom);
            r.pair_register_code = 2'($urandom);
            r.imp_op = opaddr_pkg::implied_op_t'(i < 6 ? i : $urandom_range(0, 5));
            r.stk_op = opaddr_pkg::stack_op_t'(i < 7 ? i : $urandom_range(0, 6));
            sel = (i < 12) ? 2 + (i / 8) : $urandom_range(0, 13);
            case (sel)
                0: r.mode = opaddr_pkg::mode_implied;
                1: r.mode = opaddr_pkg::mode_reg_byte;
                2: r.mode = opaddr_pkg::mode_short;
                3: r.mode = opaddr_pkg::mode_sfr;
                4: r.mode = opaddr_pkg::mode_stack;
                5: r.opcode = 8'h8e;
                6: r.opcode = 8'h85;
                7: r.opcode = 8'hae;
                8: r.opcode = 8'hab;
                9: r.mode = opaddr_pkg::mode_reg_pair;
                10: r.mode = opaddr_pkg::mode_ind_base;
                11: r.mode = opaddr_pkg::mode_based_c;
                12: r.mode = opaddr_pkg::mode_direct;
                default: r.mode = opaddr_pkg::mode_none;
            endcase
            send(r);
        end
        stop_test();
    end
endmodule : test_operand_address_generator
bind operand_address_generator opaddr_monitor mon (.clk(clk), .rst_n(rst_n), .req(req),
    .bank_select_low_flag(bank_select_low_flag), .bank_select_high_flag(bank_select_high_flag),
    .regs(regs), .stack_pointer(stack_pointer), .result(result));

// ===== zero_ext_adder.sv
`timescale 1ns/1ps
module zero_ext_adder #(
    parameter int unsigned BASE_W = 16,
    parameter int unsigned OFFS_W = 8
) (
    input wire logic [BASE_W-1:0] base,
    input wire logic [OFFS_W-1:0] offset,
    output logic [BASE_W-1:0] sum
);
    logic [BASE_W:0] full;

    // the carry out of the top bit lands in full[BASE_W] and is dropped
    always_comb begin
        full = {1'b0, base} + {{(BASE_W + 1 - OFFS_W){1'b0}}, offset};
        sum = full[BASE_W-1:0];
    end
endmodule : zero_ext_adder
